/* verilog/card_reader_mode_control.sv */
// Mode and configuration control of a USB-to-card reader bridge, with its serial slave.
// Assumes scl/sda and all pins synchronous to ref_clk_i; pad logic resolves open drain.
`timescale 1ns/1ps
`include "card_reader_defs.svh"
module card_reader_mode_control
	import card_reader_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A, // Arbitrary bus address
	parameter logic [15:0] DEFAULT_VID = 16'h1234, // Arbitrary value
	parameter logic [15:0] DEFAULT_PID = 16'h5678, // Arbitrary value
	parameter int unsigned ENUM_CYCLES = `ENUM_TIME_MS * (`CLK_HZ / 1000)
)
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic serial_ctrl_sel_i,
	input wire logic mode_pin_i,
	input wire logic supply_fault_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_b_o,
	output logic busy_b_o,
	output logic err_irq_b_o,
	output logic mcu_on_o,
	output logic usb_to_reader_o,
	output logic host_disconnect_o,
	output logic abort_xfer_o,
	output logic reader_card1_o,
	output logic reader_card2_o,
	output logic card1_switch_close_o,
	output logic card2_switch_close_o,
	output logic present_link_close_o,
	output logic card1_narrow_bus_o,
	output logic card2_narrow_bus_o,
	output logic force_full_speed_o,
	output logic [4:0] input_clock_select_o,
	output logic [3:0] card1_clock_limit_o,
	output logic [3:0] card2_clock_limit_o,
	output logic [15:0] enum_vid_o,
	output logic [15:0] enum_pid_o
);

	logic [7:0] ctl_q;
	logic [7:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [7:0] cfg3_q;
	logic [7:0] iea_q;
	logic [7:0] ieb_q;
	logic [7:0] vidh_q;
	logic [7:0] vidl_q;
	logic [7:0] pidh_q;
	logic [7:0] pidl_q;
	logic serial_q;
	logic strap_done_q;
	mode_state_t mode_q;
	logic [1:0] cur_card_q;
	logic [31:0] cnt_q;
	logic abort_q;
	logic [7:0] app_cfg1_q;
	logic [7:0] app_cfg2_q;
	logic [7:0] app_cfg3_q;
	logic [15:0] vid_q;
	logic [15:0] pid_q;
	slave_state_t sl_q;
	logic scl_q;
	logic sda_q;
	logic [7:0] sh_q;
	logic [3:0] bitc_q;
	logic addr_byte_q;
	logic ptr_byte_q;
	logic rd_q;
	logic nack_q;
	logic drive_low_q;
	logic [7:0] ptr_q;
	logic wr_q;
	logic [7:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic busy;
	logic want_reader;
	logic [1:0] tgt_card;
	logic [1:0] sel;
	logic reader_on;
	logic [31:0] cnt_last;

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `CTL_OFS)
			v = ctl_q & `CTL_MASK;
		else if (a == `CFG1_OFS)
			v = cfg1_q;
		else if (a == `CFG2_OFS)
			v = cfg2_q;
		else if (a == `CFG3_OFS)
			v = cfg3_q;
		else if (a == `IEA_OFS)
			v = iea_q;
		else if (a == `IEB_OFS)
			v = ieb_q;
		else if (a == `VIDH_OFS)
			v = vidh_q;
		else if (a == `VIDL_OFS)
			v = vidl_q;
		else if (a == `PIDH_OFS)
			v = pidh_q;
		else if (a == `PIDL_OFS)
			v = pidl_q;
		else if (a == `STAT_OFS)
			v[`STAT_BUSY] = busy;
		return v;
	endfunction

	function automatic logic [15:0] pick_id(input logic [15:0] prog, input logic [15:0] dflt);
		return (prog == `VID_ZERO) ? dflt : prog;
	endfunction

	assign start_det = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_det = scl_i & scl_q & ~sda_q & sda_i;
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign sel = ctl_q[`CTL_SEL_HI:`CTL_SEL_LO];
	assign cnt_last = ENUM_CYCLES - 32'd1;
	assign busy = (mode_q == M_ACTIVE);
	assign reader_on = (mode_q != M_SLEEP);

	// Strap is caught after reset release, never under the asynchronous reset itself
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			strap_done_q <= 1'b0;
			serial_q <= 1'b0;
		end
		else if (!strap_done_q)
		begin
			strap_done_q <= 1'b1;
			serial_q <= serial_ctrl_sel_i;
		end
	end

	always_comb
	begin
		if (serial_q)
		begin
			want_reader = ctl_q[`CTL_WAKE] & (sel == `SEL_CARD1 || sel == `SEL_CARD2);
			tgt_card = sel;
		end
		else
		begin
			want_reader = mode_pin_i;
			tgt_card = `SEL_CARD1;
		end
		if (!strap_done_q)
			want_reader = 1'b0;
	end

	// Serial slave: edges are seen from samples, so scl must stay below ref_clk_i / 4
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sl_q <= S_IDLE;
			sh_q <= 8'h00;
			bitc_q <= 4'h0;
			addr_byte_q <= 1'b0;
			ptr_byte_q <= 1'b0;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
			drive_low_q <= 1'b0;
			ptr_q <= 8'h00;
			wr_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end
		else
		begin
			wr_q <= 1'b0;
			if (start_det)
			begin
				sl_q <= S_RX;
				bitc_q <= 4'h0;
				addr_byte_q <= 1'b1;
				drive_low_q <= 1'b0;
			end
			else if (stop_det)
			begin
				sl_q <= S_IDLE;
				drive_low_q <= 1'b0;
			end
			else
			begin
				case (sl_q)
					S_RX:
					begin
						if (scl_rise)
						begin
							sh_q <= {sh_q[6:0], sda_i};
							bitc_q <= bitc_q + 4'h1;
						end
						else if (scl_fall && bitc_q == `BITS_PER_BYTE)
						begin
							bitc_q <= 4'h0;
							sl_q <= S_ACK;
							drive_low_q <= 1'b1;
							if (addr_byte_q)
							begin
								addr_byte_q <= 1'b0;
								rd_q <= sh_q[0];
								ptr_byte_q <= ~sh_q[0];
								if (sh_q[7:1] != SLAVE_ADDR)
								begin
									sl_q <= S_IDLE;
									drive_low_q <= 1'b0;
								end
							end
							else if (ptr_byte_q)
							begin
								ptr_byte_q <= 1'b0;
								ptr_q <= sh_q;
							end
							else
							begin
								wr_q <= 1'b1;
								wr_addr_q <= ptr_q;
								wr_data_q <= sh_q;
								ptr_q <= ptr_q + 8'h01;
							end
						end
					end
					S_ACK:
					begin
						if (scl_fall)
						begin
							drive_low_q <= 1'b0;
							if (rd_q)
							begin
								sh_q <= reg_read(ptr_q);
								ptr_q <= ptr_q + 8'h01;
								sl_q <= S_TX;
							end
							else
								sl_q <= S_RX;
						end
					end
					S_TX:
					begin
						if (scl_fall)
						begin
							sh_q <= {sh_q[6:0], 1'b0};
							bitc_q <= bitc_q + 4'h1;
							if (bitc_q == `BITS_PER_BYTE - 4'h1)
							begin
								bitc_q <= 4'h0;
								sl_q <= S_RACK;
							end
						end
					end
					S_RACK:
					begin
						if (scl_rise)
							nack_q <= sda_i;
						else if (scl_fall)
						begin
							if (nack_q)
								sl_q <= S_IDLE;
							else
							begin
								sh_q <= reg_read(ptr_q);
								ptr_q <= ptr_q + 8'h01;
								sl_q <= S_TX;
							end
						end
					end
					default:
						drive_low_q <= 1'b0;
				endcase
			end
		end
	end

	// Open drain: only a low is ever driven
	assign sda_o = 1'b0;
	assign sda_oe_b_o = ~(drive_low_q | (sl_q == S_TX && !sh_q[7]));

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctl_q <= `CTL_RST;
			cfg1_q <= `ZERO_RST;
			cfg2_q <= `ZERO_RST;
			cfg3_q <= `ZERO_RST;
			iea_q <= `ZERO_RST;
			ieb_q <= `ZERO_RST;
			vidh_q <= `ZERO_RST;
			vidl_q <= `ZERO_RST;
			pidh_q <= `ZERO_RST;
			pidl_q <= `ZERO_RST;
		end
		else if (wr_q)
		begin
			if (wr_addr_q == `CTL_OFS)
				ctl_q <= wr_data_q & `CTL_MASK;
			else if (wr_addr_q == `CFG1_OFS)
				cfg1_q <= wr_data_q;
			else if (wr_addr_q == `CFG2_OFS)
				cfg2_q <= wr_data_q;
			else if (wr_addr_q == `CFG3_OFS)
				cfg3_q <= wr_data_q;
			else if (wr_addr_q == `IEA_OFS)
				iea_q <= wr_data_q;
			else if (wr_addr_q == `IEB_OFS)
				ieb_q <= wr_data_q;
			else if (wr_addr_q == `VIDH_OFS)
				vidh_q <= wr_data_q;
			else if (wr_addr_q == `VIDL_OFS)
				vidl_q <= wr_data_q;
			else if (wr_addr_q == `PIDH_OFS)
				pidh_q <= wr_data_q;
			else if (wr_addr_q == `PIDL_OFS)
				pidl_q <= wr_data_q;
		end
	end

	// Mode sequencer; enumeration and teardown each take ENUM_CYCLES
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mode_q <= M_SLEEP;
			cur_card_q <= `SEL_NONE;
			cnt_q <= 32'd0;
			abort_q <= 1'b0;
			app_cfg1_q <= `ZERO_RST;
			app_cfg2_q <= `ZERO_RST;
			app_cfg3_q <= `ZERO_RST;
			vid_q <= DEFAULT_VID;
			pid_q <= DEFAULT_PID;
		end
		else
		begin
			abort_q <= 1'b0;
			case (mode_q)
				M_SLEEP:
				begin
					cnt_q <= 32'd0;
					if (want_reader)
					begin
						mode_q <= M_ENUM;
						cur_card_q <= tgt_card;
						app_cfg1_q <= cfg1_q;
						app_cfg2_q <= cfg2_q;
						app_cfg3_q <= cfg3_q;
						if (!serial_q)
							app_cfg2_q[`CFG2_CLKSEL_HI:0] <= `CLKSEL_DEFAULT;
						vid_q <= pick_id({vidh_q, vidl_q}, DEFAULT_VID);
						pid_q <= pick_id({pidh_q, pidl_q}, DEFAULT_PID);
					end
				end
				M_ENUM:
				begin
					cnt_q <= cnt_q + 32'd1;
					if (!want_reader || tgt_card != cur_card_q)
					begin
						mode_q <= M_DEENUM;
						cnt_q <= 32'd0;
					end
					else if (cnt_q == cnt_last)
						mode_q <= M_ACTIVE;
				end
				M_ACTIVE:
				begin
					cnt_q <= 32'd0;
					if (!want_reader)
					begin
						abort_q <= 1'b1;
						mode_q <= M_DEENUM;
					end
					else if (tgt_card != cur_card_q)
						mode_q <= M_DEENUM;
				end
				default:
				begin
					cnt_q <= cnt_q + 32'd1;
					if (cnt_q == cnt_last)
						mode_q <= M_SLEEP;
				end
			endcase
		end
	end

	assign busy_b_o = ~busy;
	// error pin in simple control; interrupt logic is not part of this block
	assign err_irq_b_o = serial_q | ~(reader_on & supply_fault_i);
	assign mcu_on_o = reader_on;
	assign usb_to_reader_o = reader_on;
	assign host_disconnect_o = reader_on;
	assign abort_xfer_o = abort_q;
	assign reader_card1_o = reader_on & (cur_card_q == `SEL_CARD1);
	assign reader_card2_o = reader_on & (cur_card_q == `SEL_CARD2);
	assign card1_switch_close_o = ctl_q[`CTL_SW1] & ~reader_card1_o;
	assign card2_switch_close_o = ctl_q[`CTL_SW2] & ~reader_card2_o;
	assign present_link_close_o = card1_switch_close_o;
	assign card1_narrow_bus_o = app_cfg1_q[`CFG1_NARROW1];
	assign card2_narrow_bus_o = app_cfg1_q[`CFG1_NARROW2];
	assign force_full_speed_o = app_cfg2_q[`CFG2_FORCE_FS];
	assign input_clock_select_o = app_cfg2_q[`CFG2_CLKSEL_HI:0];
	assign card1_clock_limit_o = app_cfg3_q[3:0];
	assign card2_clock_limit_o = app_cfg3_q[7:4];
	assign enum_vid_o = vid_q;
	assign enum_pid_o = pid_q;

endmodule // card_reader_mode_control

/* verilog/card_reader_defs.svh */
// Register offsets, reset values, field positions and timing for the reader mode control.
// Assumes a single 20 MHz clock; included by its bare name.
`ifndef CARD_READER_DEFS_SVH
`define CARD_READER_DEFS_SVH
`define CTL_OFS 8'h00
`define CFG1_OFS 8'h01
`define CFG2_OFS 8'h02
`define CFG3_OFS 8'h03
`define IEA_OFS 8'h04
`define IEB_OFS 8'h05
`define VIDH_OFS 8'h06
`define VIDL_OFS 8'h07
`define PIDH_OFS 8'h08
`define PIDL_OFS 8'h09
`define STAT_OFS 8'h12
`define CTL_RST 8'h18
`define ZERO_RST 8'h00
`define CTL_MASK 8'h1F
`define CTL_WAKE 0
`define CTL_SEL_LO 1
`define CTL_SEL_HI 2
`define CTL_SW1 3
`define CTL_SW2 4
`define SEL_NONE 2'h0
`define SEL_CARD1 2'h1
`define SEL_CARD2 2'h2
`define SEL_BOTH 2'h3
`define CFG1_IRQ_HI 0
`define CFG1_IRQ_PULSE 1
`define CFG1_NARROW1 2
`define CFG1_NARROW2 3
`define CFG2_FORCE_FS 7
`define CFG2_CLKSEL_HI 4
`define CLKSEL_DEFAULT 5'h00
`define VID_ZERO 16'h0000
`define STAT_BUSY 0
`define CLK_HZ 20000000
`define ENUM_TIME_MS 100
`define BITS_PER_BYTE 4'h8
`endif

/* verilog/card_reader_pkg.sv */
// Types shared by the reader mode control: mode and serial-slave states.
// No timing or offsets live here; see card_reader_defs.svh.
package card_reader_pkg;
	typedef enum logic [1:0] {M_SLEEP, M_ENUM, M_ACTIVE, M_DEENUM} mode_state_t;
	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} slave_state_t;
endpackage

/* verif/card_reader_mode_chk.sv */
// Checker: pin relations of the reader mode control, bound to its top module.
// Assumes one clock domain; port names match those of the design.
`timescale 1ns/1ps
module card_reader_mode_chk
#(
	parameter int unsigned ENUM_CYCLES = 12
)
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic serial_ctrl_sel_i,
	input wire logic mode_pin_i,
	input wire logic supply_fault_i,
	input wire logic busy_b_o,
	input wire logic err_irq_b_o,
	input wire logic mcu_on_o,
	input wire logic usb_to_reader_o,
	input wire logic host_disconnect_o,
	input wire logic abort_xfer_o,
	input wire logic reader_card1_o,
	input wire logic reader_card2_o,
	input wire logic card1_switch_close_o,
	input wire logic card2_switch_close_o,
	input wire logic present_link_close_o
);
	localparam int ENUM_WAIT = 200;
	logic [31:0] on_cnt_q;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Awake cycles; busy may not fall before enumeration had its time
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			on_cnt_q <= '0;
		else if (!mcu_on_o)
			on_cnt_q <= '0;
		else
			on_cnt_q <= on_cnt_q + 32'h1;
	end
	sequence s_enum_done;
		$fell(busy_b_o);
	endsequence
	sequence s_simple_rise;
		$rose(mode_pin_i) && !serial_ctrl_sel_i && !mcu_on_o;
	endsequence
	a_link_follows_sw1: assert property (
		present_link_close_o == card1_switch_close_o)
		else $error("present link differs from card 1 switches");
	a_usb_routed: assert property (
		usb_to_reader_o == mcu_on_o && host_disconnect_o == mcu_on_o)
		else $error("usb routing differs from awake state");
	a_busy_needs_card: assert property (
		!busy_b_o |-> mcu_on_o && (reader_card1_o || reader_card2_o))
		else $error("busy low without an attached card");
	a_asleep_no_card: assert property (
		!mcu_on_o |-> !reader_card1_o && !reader_card2_o)
		else $error("card attached while asleep");
	a_card1_sw_ignored: assert property (
		reader_card1_o |-> !card1_switch_close_o)
		else $error("card 1 switches closed in reader mode");
	a_card2_sw_ignored: assert property (
		reader_card2_o |-> !card2_switch_close_o)
		else $error("card 2 switches closed in reader mode");
	a_one_card_only: assert property (
		!(reader_card1_o && reader_card2_o))
		else $error("both cards attached to the reader");
	a_abort_one_pulse: assert property (
		abort_xfer_o |=> !abort_xfer_o)
		else $error("abort longer than one cycle");
	a_abort_drops_busy: assert property (
		abort_xfer_o |-> ##[0:1] busy_b_o)
		else $error("busy still low after abort");
	a_enum_not_early: assert property (
		s_enum_done |-> on_cnt_q >= ENUM_CYCLES - 2)
		else $error("busy fell before enumeration time");
	a_simple_rise_busy: assert property (
		s_simple_rise |-> ##[1:ENUM_WAIT] !busy_b_o)
		else $error("mode pin rise did not lower busy");
	a_err_only_awake: assert property (
		!err_irq_b_o |-> mcu_on_o && supply_fault_i && !serial_ctrl_sel_i)
		else $error("error pin low without an awake simple-control fault");
endmodule // card_reader_mode_chk

bind card_reader_mode_control card_reader_mode_chk #(.ENUM_CYCLES(ENUM_CYCLES)) u_chk (.*);

/* verif/host_serial_model.sv */
// Host processor model: bit-level serial master on an open-drain data line.
// Assumes the device samples scl and sda on clk_i; each phase lasts 4 clocks.
`timescale 1ns/1ps
module host_serial_model
#(
	parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
	input wire logic clk_i,
	input wire logic sda_oe_b_i,
	output logic scl_o,
	output logic sda_o
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	assign scl_o = m_scl;
	// Pull-up: the line is low only while a party pulls it
	assign sda_o = m_sda & sda_oe_b_i;
	task automatic tick();
		repeat (4) @(posedge clk_i);
		#2;
	endtask
	task automatic start();
		m_sda = 1'b1;
		tick();
		m_scl = 1'b1;
		tick();
		m_sda = 1'b0;
		tick();
		m_scl = 1'b0;
	endtask
	task automatic stop();
		@(posedge clk_i) #2;
		m_sda = 1'b0;
		tick();
		m_scl = 1'b1;
		tick();
		m_sda = 1'b1;
		tick();
	endtask
	// Nine bits; the ninth is released for ack, or is our own nack
	task automatic xb(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		logic [8:0] sh;
		sh = {tx, last};
		for (int i = 8; i >= 0; i--)
		begin
			@(posedge clk_i) #2;
			m_sda = sh[i];
			tick();
			m_scl = 1'b1;
			tick();
			sh[i] = sda_o;
			m_scl = 1'b0;
		end
		rx = sh[8:1];
		ack = sh[0];
	endtask
	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic [2:0] k;
		start();
		xb({DEV_ADDR, 1'b0}, 1'b1, r, k[0]);
		xb(ptr, 1'b1, r, k[1]);
		xb(d, 1'b1, r, k[2]);
		stop();
		nak = |k;
	endtask
	task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic [2:0] k;
		start();
		xb({DEV_ADDR, 1'b0}, 1'b1, r, k[0]);
		xb(ptr, 1'b1, r, k[1]);
		start();
		xb({DEV_ADDR, 1'b1}, 1'b1, r, k[2]);
		xb(8'hFF, 1'b1, d, r[0]);
		stop();
		nak = |k;
	endtask
endmodule // host_serial_model

/* verif/tb_top.sv */
// Self-checking bench for the reader mode control, driven through a host model.
// Assumes the design, checker and host model are compiled before this file.
`timescale 1ns/1ps
module tb_top;
	localparam int EC = 40;
	localparam logic [15:0] DV = 16'h1234; // Arbitrary value
	localparam logic [15:0] DP = 16'h5678; // Arbitrary value
	logic clk, rst_b, sel, mode, fault, scl, sda, oe_b, sda_o, nak;
	logic busy_b, err_b, on, to_rdr, dc, abort, rc1, rc2, sw1, sw2, plink, nb1, nb2, ffs;
	logic [4:0] csel;
	logic [3:0] cl1, cl2;
	logic [15:0] vid, pid;
	logic [7:0] d;
	logic busy_p = 1'b1;
	int num_errors = 0;
	int checks_done = 0;
	int seed = 54;
	int n_abort = 0;
	int n_rise = 0;
	int r0;
	int mdl[10];
	card_reader_mode_control #(.DEFAULT_VID(DV), .DEFAULT_PID(DP), .ENUM_CYCLES(EC)) dut (
		.ref_clk_i(clk), .rst_b_i(rst_b), .serial_ctrl_sel_i(sel), .mode_pin_i(mode),
		.supply_fault_i(fault), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_b_o(oe_b),
		.busy_b_o(busy_b), .err_irq_b_o(err_b), .mcu_on_o(on), .usb_to_reader_o(to_rdr),
		.host_disconnect_o(dc), .abort_xfer_o(abort), .reader_card1_o(rc1),
		.reader_card2_o(rc2), .card1_switch_close_o(sw1), .card2_switch_close_o(sw2),
		.present_link_close_o(plink), .card1_narrow_bus_o(nb1), .card2_narrow_bus_o(nb2),
		.force_full_speed_o(ffs), .input_clock_select_o(csel), .card1_clock_limit_o(cl1),
		.card2_clock_limit_o(cl2), .enum_vid_o(vid), .enum_pid_o(pid));
	host_serial_model h (.clk_i(clk), .sda_oe_b_i(oe_b), .scl_o(scl), .sda_o(sda));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Falling edge: outputs launched on the rising edge have settled
	always @(negedge clk)
	begin
		if (abort === 1'b1)
			n_abort++;
		if (busy_b === 1'b1 && busy_p === 1'b0)
			n_rise++;
		busy_p = busy_b;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [15:0] idv(int hi, int lo, logic [15:0] dflt);
		idv = {hi[7:0], lo[7:0]};
		if (idv == 16'h0000)
			idv = dflt;
	endfunction
	task automatic do_reset(input logic s);
		rst_b = 1'b0;
		sel = s;
		mdl = '{default: 0};
		mdl[0] = 8'h18;
		repeat (4) @(posedge clk);
		#2;
		rst_b = 1'b1;
		repeat (2) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		h.reg_wr(a, v, nak);
		chk(nak, 1'b0);
		// Reserved control bits are dropped by the device
		if (a < 8'h0A)
			mdl[a] = (a == 8'h00) ? (v & 8'h1F) : v;
	endtask
	task automatic rd_chk(input logic [7:0] a, input int exp);
		h.reg_rd(a, d, nak);
		chk(nak, 1'b0);
		chk(d, 16'(exp));
	endtask
	// Bounded wait on busy (w=0) or the awake flag (w=1)
	task automatic wt(input logic w, input logic lvl);
		repeat (400)
			if ((w ? on : busy_b) !== lvl)
				@(posedge clk) #2;
		chk(w ? on : busy_b, lvl);
	endtask
	task automatic rdr(input logic c2);
		chk(on, 1'b1);
		chk(to_rdr, 1'b1);
		chk(dc, 1'b1);
		chk(rc1, !c2);
		chk(rc2, c2);
		chk(c2 ? sw2 : sw1, 1'b0);
		chk(c2 ? sw1 : sw2, c2 ? mdl[0][3] : mdl[0][4]);
		chk(plink, c2 ? mdl[0][3] : 1'b0);
		chk(nb1, mdl[1][2]);
		chk(nb2, mdl[1][3]);
		chk(ffs, mdl[2][7]);
		chk(csel, mdl[2][4:0]);
		chk(vid, idv(mdl[6], mdl[7], DV));
		chk(pid, idv(mdl[8], mdl[9], DP));
		chk(cl1, mdl[3][3:0]);
		chk(cl2, mdl[3][7:4]);
		chk(sda_o, 1'b0);
	endtask
	initial
	begin
		rst_b = 1'b0;
		sel = 1'b1;
		mode = 1'b0;
		fault = 1'b0;
		do_reset(1'b1);
		chk(busy_b, 1'b1);
		chk(sw1 & sw2 & plink, 1'b1);
		for (int i = 0; i < 10; i++)
			rd_chk(8'(i), mdl[i]);
		rd_chk(8'h0A, 0);
		rd_chk(8'h12, 0);
		h.start();
		h.xb(8'h2A, 1'b1, d, nak);
		h.stop();
		chk(nak, 1'b1);
		// Settings land at once; config and ID registers wait for reader entry to apply, interrupt enables never apply
		for (int i = 9; i >= 0; i--)
			wr(8'(i), 8'($random(seed)) & ((i != 0) ? 8'hFF : 8'hFE));
		for (int i = 0; i < 10; i++)
			rd_chk(8'(i), mdl[i]);
		chk(on, 1'b0);
		chk({sw2, sw1}, mdl[0][4:3]);
		chk(vid, DV);
		for (int s = 0; s < 4; s += 3)
		begin
			wr(8'h00, 8'((mdl[0] & 8'h18) | (s << 1) | 1));
			repeat (EC + 20) @(posedge clk) #2;
			chk(on, 1'b0);
		end
		wr(8'h00, 8'((mdl[0] & 8'h18) | 8'h03));
		wt(1'b0, 1'b0);
		rdr(1'b0);
		rd_chk(8'h12, 1);
		r0 = n_rise;
		wr(8'h00, 8'((mdl[0] & 8'h18) | 8'h05));
		wt(1'b0, 1'b1);
		wt(1'b0, 1'b0);
		chk(16'(n_rise - r0), 16'h0001);
		rdr(1'b1);
		r0 = n_abort;
		wr(8'h00, 8'(mdl[0] & 8'h1C));
		chk(on, 1'b1);
		wt(1'b1, 1'b0);
		chk(16'(n_abort - r0), 16'h0001);
		chk({busy_b, rc2}, 2'b10);
		chk({sw2, plink}, mdl[0][4:3]);
		rd_chk(8'h12, 0);
		// Simple control, single card
		do_reset(1'b0);
		// A stored clock choice must not reach the pins in simple control
		h.reg_wr(8'h02, 8'h1F, nak);
		chk(nak, 1'b0);
		fault = 1'b1;
		mode = 1'b1;
		wt(1'b0, 1'b0);
		rdr(1'b0);
		chk(err_b, 1'b0);
		mode = 1'b0;
		wt(1'b1, 1'b0);
		chk({busy_b, err_b, sw1, plink}, 4'hF);
		stop_test();
	end
	// About 14k cycles of traffic expected; 60k cuts a hang short
	initial
	begin
		#3000000;
		num_errors++;
		stop_test();
	end
endmodule // tb_top
